// ### design/pfd_program_flow_decoder.sv
// program flow decoder: fetch, jumps, calls, call_exit and copy_op dispatch
`timescale 1ns/1ps
`include "pfd_params.svh"

module pfd_program_flow_decoder
  import pfd_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // program memory, data one cycle after code_req
  output logic             code_req,
  output logic [15:0]      code_addr,
  input  wire logic [7:0]  code_rdata,
  // internal ram stack, read data one cycle after ram_re
  output logic             ram_we,
  output logic             ram_re,
  output logic [7:0]       ram_addr,
  output logic [7:0]       ram_wdata,
  input  wire logic [7:0]  ram_rdata,
  // copy_op dispatch to the datapath
  output logic             copy_valid,
  output pfd_mode_e        copy_dst_mode,
  output logic [7:0]       copy_dst_arg,
  output pfd_mode_e        copy_src_mode,
  output logic [7:0]       copy_src_arg,
  output logic             copy_imm,
  // opcodes outside this block
  output logic             other_valid,
  output logic [7:0]       other_opcode,
  // core state
  output logic [15:0]      pc,
  output logic [7:0]       sp,
  output logic             flow_taken
);

  pfd_state_e  state;
  pfd_state_e  next_state;
  logic [1:0]  idx;
  logic [1:0]  next_idx;
  logic [1:0]  len;
  logic [1:0]  next_len;
  logic [7:0]  opcode;
  logic [7:0]  next_opcode;
  logic [7:0]  byte1;
  logic [7:0]  next_byte1;
  logic [7:0]  byte2;
  logic [7:0]  next_byte2;
  logic [15:0] target;
  logic [15:0] next_target;
  logic [15:0] next_pc;
  logic [7:0]  next_sp;
  logic        next_flow_taken;
  logic        next_copy_valid;
  pfd_mode_e   next_copy_dst_mode;
  logic [7:0]  next_copy_dst_arg;
  pfd_mode_e   next_copy_src_mode;
  logic [7:0]  next_copy_src_arg;
  logic        next_copy_imm;
  logic        next_other_valid;
  logic [7:0]  next_other_opcode;

  // classifier inputs and results
  logic        first_byte;
  logic [7:0]  op_sel;
  logic        cls_copy;
  logic [1:0]  cls_len;
  pfd_mode_e   cls_dst_mode;
  logic [7:0]  cls_dst_arg;
  pfd_mode_e   cls_src_mode;
  logic [7:0]  cls_src_arg;
  logic [1:0]  len_now;
  logic [15:0] rel_target;
  logic [15:0] block_target;

  // the opcode byte is classified as it arrives so its length is known at once
  assign first_byte = (state == PFD_S_GET) && (idx == 2'h0);
  assign op_sel     = first_byte ? code_rdata : opcode;
  assign len_now    = first_byte ? cls_len : len;

  pfd_copy_classify u_classify (
    .opcode   (op_sel),
    .byte1    (byte1),
    .byte2    (byte2),
    .is_copy  (cls_copy),
    .op_len   (cls_len),
    .dst_mode (cls_dst_mode),
    .dst_arg  (cls_dst_arg),
    .src_mode (cls_src_mode),
    .src_arg  (cls_src_arg)
  );

  // pc already points past the instruction when these are used
  assign rel_target   = pc + {{8{byte1[7]}}, byte1};
  assign block_target = {pc[15:`PFD_BLOCK_LSB], opcode[7:5], byte1};

  always_comb begin
    next_state         = state;
    next_idx           = idx;
    next_len           = len;
    next_opcode        = opcode;
    next_byte1         = byte1;
    next_byte2         = byte2;
    next_target        = target;
    next_pc            = pc;
    next_sp            = sp;
    next_flow_taken    = 1'b0;
    next_copy_valid    = 1'b0;
    next_copy_dst_mode = copy_dst_mode;
    next_copy_dst_arg  = copy_dst_arg;
    next_copy_src_mode = copy_src_mode;
    next_copy_src_arg  = copy_src_arg;
    next_copy_imm      = copy_imm;
    next_other_valid   = 1'b0;
    next_other_opcode  = other_opcode;
    code_req           = 1'b0;
    code_addr          = pc;
    ram_we             = 1'b0;
    ram_re             = 1'b0;
    ram_addr           = sp;
    ram_wdata          = 8'h00;
    unique case (state)
      PFD_S_FETCH: begin
        code_req   = 1'b1;
        next_state = PFD_S_GET;
      end
      PFD_S_GET: begin
        next_pc = pc + 16'h0001;
        if (idx == 2'h0) begin
          next_opcode = code_rdata;
          next_len    = cls_len;
        end else if (idx == 2'h1) begin
          next_byte1 = code_rdata;
        end else begin
          next_byte2 = code_rdata;
        end
        if (idx + 2'h1 == len_now) begin
          next_idx   = 2'h0;
          next_state = PFD_S_EXEC;
        end else begin
          next_idx   = idx + 2'h1;
          next_state = PFD_S_FETCH;
        end
      end
      PFD_S_EXEC: begin
        next_state = PFD_S_FETCH;
        if (cls_copy) begin
          // datapath stores the source value, or the literal when immediate
          next_copy_valid    = 1'b1;
          next_copy_dst_mode = cls_dst_mode;
          next_copy_dst_arg  = cls_dst_arg;
          next_copy_src_mode = cls_src_mode;
          next_copy_src_arg  = cls_src_arg;
          next_copy_imm      = (cls_src_mode == PFD_M_IMM);
        end else if (opcode == `PFD_OP_LONG_JUMP) begin
          next_pc         = {byte1, byte2};
          next_flow_taken = 1'b1;
        end else if (opcode == `PFD_OP_SHORT_JUMP) begin
          next_pc         = rel_target;
          next_flow_taken = 1'b1;
        end else if (opcode[4:0] == `PFD_BLOCK_FIELD) begin
          next_pc         = block_target;
          next_flow_taken = 1'b1;
        end else if (opcode == `PFD_OP_LONG_CALL) begin
          next_target = {byte1, byte2};
          next_state  = PFD_S_PUSH_LO;
        end else if (opcode[4:0] == `PFD_BLOCK_CALL_F) begin
          next_target = block_target;
          next_state  = PFD_S_PUSH_LO;
        end else if (opcode == `PFD_OP_CALL_EXIT) begin
          next_state = PFD_S_POP_HI;
        end else begin
          next_other_valid  = 1'b1;
          next_other_opcode = opcode;
        end
      end
      PFD_S_PUSH_LO: begin
        // low byte of the return address goes first, one slot above sp
        ram_we     = 1'b1;
        ram_addr   = sp + 8'h01;
        ram_wdata  = pc[7:0];
        next_sp    = sp + 8'h01;
        next_state = PFD_S_PUSH_HI;
      end
      PFD_S_PUSH_HI: begin
        ram_we          = 1'b1;
        ram_addr        = sp + 8'h01;
        ram_wdata       = pc[15:8];
        next_sp         = sp + 8'h01;
        next_pc         = target;
        next_flow_taken = 1'b1;
        next_state      = PFD_S_FETCH;
      end
      PFD_S_POP_HI: begin
        ram_re     = 1'b1;
        ram_addr   = sp;
        next_sp    = sp - 8'h01;
        next_state = PFD_S_POP_LO;
      end
      PFD_S_POP_LO: begin
        next_pc    = {ram_rdata, pc[7:0]};
        ram_re     = 1'b1;
        ram_addr   = sp;
        next_sp    = sp - 8'h01;
        next_state = PFD_S_POP_DONE;
      end
      PFD_S_POP_DONE: begin
        next_pc         = {pc[15:8], ram_rdata};
        next_flow_taken = 1'b1;
        next_state      = PFD_S_FETCH;
      end
    endcase
  end

  // stack wraps within 256 bytes; overflow is the program's problem, not trapped here
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state         <= PFD_S_FETCH;
      idx           <= 2'h0;
      len           <= `PFD_LEN_ONE;
      opcode        <= 8'h00;
      byte1         <= 8'h00;
      byte2         <= 8'h00;
      target        <= 16'h0000;
      pc            <= `PFD_PC_RESET;
      sp            <= `PFD_SP_RESET;
      flow_taken    <= 1'b0;
      copy_valid    <= 1'b0;
      copy_dst_mode <= PFD_M_NONE;
      copy_dst_arg  <= 8'h00;
      copy_src_mode <= PFD_M_NONE;
      copy_src_arg  <= 8'h00;
      copy_imm      <= 1'b0;
      other_valid   <= 1'b0;
      other_opcode  <= 8'h00;
    end else begin
      state         <= next_state;
      idx           <= next_idx;
      len           <= next_len;
      opcode        <= next_opcode;
      byte1         <= next_byte1;
      byte2         <= next_byte2;
      target        <= next_target;
      pc            <= next_pc;
      sp            <= next_sp;
      flow_taken    <= next_flow_taken;
      copy_valid    <= next_copy_valid;
      copy_dst_mode <= next_copy_dst_mode;
      copy_dst_arg  <= next_copy_dst_arg;
      copy_src_mode <= next_copy_src_mode;
      copy_src_arg  <= next_copy_src_arg;
      copy_imm      <= next_copy_imm;
      other_valid   <= next_other_valid;
      other_opcode  <= next_other_opcode;
    end
  end

endmodule

// ### shared/pfd_params.svh
// constants for the program flow decoder: opcodes, lengths, reset values
`ifndef PFD_PARAMS_SVH
`define PFD_PARAMS_SVH

`define PFD_PC_RESET      16'h0000
`define PFD_SP_RESET      8'h07

`define PFD_OP_LONG_JUMP  8'h02
`define PFD_OP_SHORT_JUMP 8'h80
`define PFD_OP_LONG_CALL  8'h12
`define PFD_OP_CALL_EXIT  8'h22
`define PFD_BLOCK_FIELD   5'h01
`define PFD_BLOCK_CALL_F  5'h11
`define PFD_BLOCK_LSB     11

`define PFD_LEN_ONE       2'h1
`define PFD_LEN_TWO       2'h2
`define PFD_LEN_THREE     2'h3

`endif

// ### shared/pfd_pkg.sv
// types shared by the program flow decoder modules
package pfd_pkg;

  typedef enum logic [2:0] {
    PFD_S_FETCH    = 3'b000,
    PFD_S_GET      = 3'b001,
    PFD_S_EXEC     = 3'b010,
    PFD_S_PUSH_LO  = 3'b011,
    PFD_S_PUSH_HI  = 3'b100,
    PFD_S_POP_HI   = 3'b101,
    PFD_S_POP_LO   = 3'b110,
    PFD_S_POP_DONE = 3'b111
  } pfd_state_e;

  typedef enum logic [2:0] {
    PFD_M_NONE  = 3'b000,
    PFD_M_ACC   = 3'b001,
    PFD_M_BANK  = 3'b010,
    PFD_M_IND   = 3'b011,
    PFD_M_DIR   = 3'b100,
    PFD_M_IMM   = 3'b101,
    PFD_M_BIT   = 3'b110,
    PFD_M_CARRY = 3'b111
  } pfd_mode_e;

endpackage

// ### design/pfd_copy_classify.sv
// opcode classifier: copy_op operand modes and instruction length
`timescale 1ns/1ps
`include "pfd_params.svh"

module pfd_copy_classify
  import pfd_pkg::*;
(
  // instruction bytes
  input  wire logic [7:0] opcode,
  input  wire logic [7:0] byte1,
  input  wire logic [7:0] byte2,
  // classification
  output logic            is_copy,
  output logic [1:0]      op_len,
  output pfd_mode_e       dst_mode,
  output logic [7:0]      dst_arg,
  output pfd_mode_e       src_mode,
  output logic [7:0]      src_arg
);

  logic [7:0] bank_idx;
  logic [7:0] ind_idx;

  assign bank_idx = {5'h00, opcode[2:0]};
  assign ind_idx  = {7'h00, opcode[0]};

  always_comb begin
    is_copy  = 1'b1;
    op_len   = `PFD_LEN_TWO;
    dst_mode = PFD_M_NONE;
    dst_arg  = 8'h00;
    src_mode = PFD_M_NONE;
    src_arg  = 8'h00;
    // 57 copy_op variants; the 16-bit pointer load is not among them
    casez (opcode)
      8'h74: begin
        dst_mode = PFD_M_ACC;
        src_mode = PFD_M_IMM;
        src_arg  = byte1;
      end
      8'h75: begin
        op_len   = `PFD_LEN_THREE;
        dst_mode = PFD_M_DIR;
        dst_arg  = byte1;
        src_mode = PFD_M_IMM;
        src_arg  = byte2;
      end
      8'b0111_011?: begin
        dst_mode = PFD_M_IND;
        dst_arg  = ind_idx;
        src_mode = PFD_M_IMM;
        src_arg  = byte1;
      end
      8'b0111_1???: begin
        dst_mode = PFD_M_BANK;
        dst_arg  = bank_idx;
        src_mode = PFD_M_IMM;
        src_arg  = byte1;
      end
      8'h85: begin
        // source address is encoded before the destination
        op_len   = `PFD_LEN_THREE;
        dst_mode = PFD_M_DIR;
        dst_arg  = byte2;
        src_mode = PFD_M_DIR;
        src_arg  = byte1;
      end
      8'b1000_011?: begin
        dst_mode = PFD_M_DIR;
        dst_arg  = byte1;
        src_mode = PFD_M_IND;
        src_arg  = ind_idx;
      end
      8'b1000_1???: begin
        dst_mode = PFD_M_DIR;
        dst_arg  = byte1;
        src_mode = PFD_M_BANK;
        src_arg  = bank_idx;
      end
      8'h92: begin
        dst_mode = PFD_M_BIT;
        dst_arg  = byte1;
        src_mode = PFD_M_CARRY;
      end
      8'hA2: begin
        dst_mode = PFD_M_CARRY;
        src_mode = PFD_M_BIT;
        src_arg  = byte1;
      end
      8'b1010_011?: begin
        dst_mode = PFD_M_IND;
        dst_arg  = ind_idx;
        src_mode = PFD_M_DIR;
        src_arg  = byte1;
      end
      8'b1010_1???: begin
        dst_mode = PFD_M_BANK;
        dst_arg  = bank_idx;
        src_mode = PFD_M_DIR;
        src_arg  = byte1;
      end
      8'hE5: begin
        dst_mode = PFD_M_ACC;
        src_mode = PFD_M_DIR;
        src_arg  = byte1;
      end
      8'b1110_011?: begin
        op_len   = `PFD_LEN_ONE;
        dst_mode = PFD_M_ACC;
        src_mode = PFD_M_IND;
        src_arg  = ind_idx;
      end
      8'b1110_1???: begin
        op_len   = `PFD_LEN_ONE;
        dst_mode = PFD_M_ACC;
        src_mode = PFD_M_BANK;
        src_arg  = bank_idx;
      end
      8'hF5: begin
        dst_mode = PFD_M_DIR;
        dst_arg  = byte1;
        src_mode = PFD_M_ACC;
      end
      8'b1111_011?: begin
        op_len   = `PFD_LEN_ONE;
        dst_mode = PFD_M_IND;
        dst_arg  = ind_idx;
        src_mode = PFD_M_ACC;
      end
      8'b1111_1???: begin
        op_len   = `PFD_LEN_ONE;
        dst_mode = PFD_M_BANK;
        dst_arg  = bank_idx;
        src_mode = PFD_M_ACC;
      end
      default: begin
        is_copy = 1'b0;
        if (opcode == `PFD_OP_LONG_JUMP || opcode == `PFD_OP_LONG_CALL) begin
          op_len = `PFD_LEN_THREE;
        end else if (opcode == `PFD_OP_SHORT_JUMP) begin
          op_len = `PFD_LEN_TWO;
        end else if (opcode[4:0] == `PFD_BLOCK_FIELD || opcode[4:0] == `PFD_BLOCK_CALL_F) begin
          op_len = `PFD_LEN_TWO;
        end else begin
          // any other opcode is handed on as a single byte
          op_len = `PFD_LEN_ONE;
        end
      end
    endcase
  end

endmodule

// ### test/pfd_checker_sva.sv
// assertion checker for the program flow decoder ports
`timescale 1ns/1ps
module pfd_checker (
  // clock and reset
  input wire logic        mclk,
  input wire logic        reset_n,
  // program memory
  input wire logic        code_req,
  input wire logic [15:0] code_addr,
  // stack ram
  input wire logic        ram_we,
  input wire logic        ram_re,
  input wire logic [7:0]  ram_addr,
  input wire logic [7:0]  ram_wdata,
  input wire logic [7:0]  ram_rdata,
  // dispatch and core state
  input wire logic        copy_valid,
  input wire logic        other_valid,
  input wire logic [15:0] pc,
  input wire logic [7:0]  sp,
  input wire logic        flow_taken
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_push_low_first: assert property (ram_we && !$past(ram_we) |-> ram_addr == sp + 8'h01 && ram_wdata == pc[7:0])
    else $error("first pushed byte misplaced");
  a_push_high_next: assert property (ram_we && !$past(ram_we) |=> ram_we && ram_wdata == pc[15:8]
    && ram_addr == $past(ram_addr) + 8'h01 ##1 flow_taken && !ram_we)
    else $error("second pushed byte or jump wrong");
  a_call_grows_two: assert property (ram_we && !$past(ram_we) |-> ##2 sp == $past(sp, 2) + 8'h02)
    else $error("call did not grow stack by two");
  a_pop_order: assert property (ram_re && !$past(ram_re) |-> ram_addr == sp ##1 ram_re
    && ram_addr == $past(ram_addr) - 8'h01)
    else $error("pop order wrong");
  a_return_resume: assert property (ram_re && !$past(ram_re) |-> ##3 flow_taken
    && pc == {$past(ram_rdata, 2), $past(ram_rdata)} && sp == $past(sp, 3) - 8'h02)
    else $error("return address not resumed");
  a_flow_refetch: assert property (flow_taken |-> code_req && code_addr == pc ##1 !flow_taken)
    else $error("jump target not fetched");
  a_fetch_pace: assert property (code_req |-> code_addr == pc ##1 !code_req)
    else $error("fetch address or pacing wrong");
  a_sp_idle: assert property (!ram_we && !ram_re |=> sp == $past(sp))
    else $error("stack pointer moved without access");
  a_copy_spacing: assert property (copy_valid |-> !other_valid ##1 !copy_valid [*2])
    else $error("copy dispatch spacing wrong");

  cover property (ram_we ##1 ram_we ##1 flow_taken);
  cover property (ram_re ##1 ram_re);
  cover property (copy_valid);
  cover property (other_valid);
endmodule

bind pfd_program_flow_decoder pfd_checker u_chk (
  .mclk(mclk), .reset_n(reset_n), .code_req(code_req), .code_addr(code_addr),
  .ram_we(ram_we), .ram_re(ram_re), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata),
  .copy_valid(copy_valid), .other_valid(other_valid), .pc(pc), .sp(sp), .flow_taken(flow_taken)
);

// ### test/pfd_mem_model.sv
// behavioural program memory and stack ram facing the decoder
`timescale 1ns/1ps
module pfd_mem_model (
  // clock
  input wire logic        mclk,
  // program memory
  input wire logic        code_req,
  input wire logic [15:0] code_addr,
  output logic [7:0]      code_rdata,
  // stack ram
  input wire logic        ram_we,
  input wire logic        ram_re,
  input wire logic [7:0]  ram_addr,
  input wire logic [7:0]  ram_wdata,
  output logic [7:0]      ram_rdata
);
  logic [7:0] code_mem [0:65535];
  logic [7:0] stack    [0:255];

  initial begin
    code_rdata = 8'h00;
    ram_rdata = 8'h00;
    for (int i = 0; i < 65536; i++) code_mem[i] = 8'h00;
    for (int i = 0; i < 256; i++) stack[i] = 8'h00;
  end

  // an unrequested bus flips every cycle so stale data never passes as an answer
  always @(posedge mclk) begin
    code_rdata <= code_req ? code_mem[code_addr] : ~code_rdata;
    ram_rdata <= ram_re ? stack[ram_addr] : ~ram_rdata;
    if (ram_we) stack[ram_addr] <= ram_wdata;
  end
endmodule

// ### test/test_program_flow_decoder.sv
// self-checking bench for the program flow decoder
`timescale 1ns/1ps
`include "pfd_params.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module test_program_flow_decoder;
  import pfd_pkg::*;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic        code_req, ram_we, ram_re, copy_valid, copy_imm, other_valid, flow_taken;
  logic [15:0] code_addr, pc;
  logic [7:0]  code_rdata, ram_addr, ram_wdata, ram_rdata, copy_dst_arg, copy_src_arg, other_opcode, sp;
  pfd_mode_e   copy_dst_mode, copy_src_mode;
  int          bad_count, checks_done, cycles, req_cnt, last_len;

  pfd_program_flow_decoder dut (.mclk(mclk), .reset_n(reset_n), .code_req(code_req), .code_addr(code_addr),
    .code_rdata(code_rdata), .ram_we(ram_we), .ram_re(ram_re), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_rdata(ram_rdata), .copy_valid(copy_valid), .copy_dst_mode(copy_dst_mode), .copy_dst_arg(copy_dst_arg),
    .copy_src_mode(copy_src_mode), .copy_src_arg(copy_src_arg), .copy_imm(copy_imm), .other_valid(other_valid),
    .other_opcode(other_opcode), .pc(pc), .sp(sp), .flow_taken(flow_taken));
  pfd_mem_model mem (.mclk(mclk), .code_req(code_req), .code_addr(code_addr), .code_rdata(code_rdata),
    .ram_we(ram_we), .ram_re(ram_re), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata));

  always #5 mclk = ~mclk;

  // instruction length = fetches between two taken flows; sampled just after the falling
  // edge so a reset released on that edge is seen before the first fetch is counted
  always @(negedge mclk) begin
    #0.5;
    cycles++;
    if (cycles > 30000) begin
      bad_count++;
      results();
    end
    if (!reset_n) req_cnt = 0;
    else if (code_req && flow_taken) begin
      last_len = req_cnt;
      req_cnt = 1;
    end else if (code_req) req_cnt++;
  end

  task results;
    $display("comparisons %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task do_reset;
    reset_n = 1'b0;
    repeat (6) @(negedge mclk);
    reset_n = 1'b1;
  endtask

  task prog2(input logic [15:0] a, input logic [15:0] b);
    {mem.code_mem[a], mem.code_mem[a+16'h0001]} = b;
  endtask

  task prog3(input logic [15:0] a, input logic [23:0] b);
    {mem.code_mem[a], mem.code_mem[a+16'h0001], mem.code_mem[a+16'h0002]} = b;
  endtask

  task wait_flow(input logic [15:0] ep, input int el, input logic [7:0] es);
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      #1;
      n++;
    end while (flow_taken !== 1'b1 && n < 40);
    `CHK("target pc", ep, pc)
    `CHK("instruction length", el, last_len)
    `CHK("stack pointer", es, sp)
  endtask

  task wait_copy(input pfd_mode_e dm, input logic [7:0] da, input pfd_mode_e sm, input logic [7:0] sa,
                 input logic im);
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (copy_valid !== 1'b1 && n < 20);
    `CHK("copy dst mode", dm, copy_dst_mode)
    `CHK("copy src mode", sm, copy_src_mode)
    `CHK("copy src arg", sa, copy_src_arg)
    `CHK("copy immediate", im, copy_imm)
    if (dm != PFD_M_ACC) `CHK("copy dst arg", da, copy_dst_arg)
  endtask

  // reach limits: -128, +127, block end into the next 2k block
  task t_jumps;
    prog3(16'h0000, 24'h02_2400);
    prog2(16'h2400, 16'h8080);
    prog2(16'h2382, 16'h807F);
    prog2(16'h2403, 16'hE1FE);
    prog2(16'h27FE, 16'h0110);
    do_reset();
    wait_flow(16'h2400, 3, `PFD_SP_RESET);
    wait_flow(16'h2382, 2, `PFD_SP_RESET);
    wait_flow(16'h2403, 2, `PFD_SP_RESET);
    wait_flow(16'h27FE, 2, `PFD_SP_RESET);
    wait_flow(16'h2810, 2, `PFD_SP_RESET);
  endtask

  // nested calls then both returns
  task t_calls;
    prog3(16'h0000, 24'h02_1234);
    prog3(16'h1234, 24'h12_3000);
    prog2(16'h3000, 16'h7140);
    mem.code_mem[16'h3340] = 8'h22;
    mem.code_mem[16'h3002] = 8'h22;
    do_reset();
    wait_flow(16'h1234, 3, 8'h07);
    wait_flow(16'h3000, 3, 8'h09);
    `CHK("stack low byte", 8'h37, mem.stack[8'h08])
    `CHK("stack high byte", 8'h12, mem.stack[8'h09])
    wait_flow(16'h3340, 2, 8'h0B);
    `CHK("nested low byte", 8'h02, mem.stack[8'h0A])
    `CHK("nested high byte", 8'h30, mem.stack[8'h0B])
    wait_flow(16'h3002, 1, 8'h09);
    wait_flow(16'h1237, 1, 8'h07);
  endtask

  task t_copy;
    prog2(16'h0000, 16'h7425);
    prog3(16'h0002, 24'h75_4055);
    prog3(16'h0005, 24'h85_3040);
    do_reset();
    wait_copy(PFD_M_ACC, 8'h00, PFD_M_IMM, 8'h25, 1'b1);
    wait_copy(PFD_M_DIR, 8'h40, PFD_M_IMM, 8'h55, 1'b1);
    wait_copy(PFD_M_DIR, 8'h40, PFD_M_DIR, 8'h30, 1'b0);
  endtask

  // every non-flow opcode: copy or other, and the copy total
  task t_sweep;
    int copies;
    int n;
    copies = 0;
    for (int op = 0; op < 256; op++) begin
      if (op inside {'h02, 'h12, 'h22, 'h80} || op[4:0] == 5'h01 || op[4:0] == 5'h11) continue;
      mem.code_mem[16'h0000] = op[7:0];
      do_reset();
      n = 0;
      do begin
        @(negedge mclk);
        n++;
      end while (copy_valid !== 1'b1 && other_valid !== 1'b1 && n < 16);
      `CHK("copy decode", op inside {['h74:'h7F], ['h85:'h8F], 'h92, 'hA2, ['hA6:'hAF], ['hE5:'hEF], ['hF5:'hFF]},
           copy_valid)
      if (copy_valid === 1'b1) copies++;
    end
    `CHK("copy opcode count", 57, copies)
  endtask

  initial begin
    @(negedge mclk);
    t_jumps();
    t_calls();
    t_copy();
    t_sweep();
    results();
  end
endmodule
